// ===== rtl/adsc_defs.vh
`ifndef ADSC_DEFS_VH
`define ADSC_DEFS_VH
// register offsets (byte-wide i/o space)
`define ADSC_OFS_START_LOW 4'h0
`define ADSC_OFS_RESULT_HIGH 4'h1
`define ADSC_OFS_CHAN_SPAN 4'h2
`define ADSC_OFS_STATUS 4'h8
`define ADSC_OFS_RANGE_CFG 4'hb
// field positions
`define ADSC_SPAN_LOW_LSB 0
`define ADSC_SPAN_HIGH_LSB 4
`define ADSC_STAT_BUSY_BIT 7
`define ADSC_CFG_OUT_POL_BIT 4
`define ADSC_CFG_RANGE_BIT 3
`define ADSC_CFG_IN_POL_BIT 2
`define ADSC_CFG_GAIN_LSB 0
`define ADSC_CFG_MASK 8'h1f
// reset values
`define ADSC_CFG_RESET 8'h00
`define ADSC_SPAN_RESET 8'h00
// timing: longest conversion time and derived cycle count at 100 mhz
`define ADSC_CONV_MAX_NS 10000
`define ADSC_CLK_NS 10
`define ADSC_CONV_CYCLES (`ADSC_CONV_MAX_NS / `ADSC_CLK_NS)
// output converter channel shape
`define ADSC_DAC_CHANNELS 4
`define ADSC_DAC_MAX 12'hfff
`endif

// ===== rtl/adsc_chan_counter.v
`include "adsc_defs.vh"
`default_nettype none
// current-channel counter that steps through a low..high span and wraps
module adsc_chan_counter #(
    parameter CW = 4
) (
    // clock and reset
    input wire clk_i,
    input wire nrst_i,
    // control
    input wire load_i,
    input wire [CW-1:0] low_i,
    input wire [CW-1:0] high_i,
    input wire advance_i,
    // state
    output wire [CW-1:0] chan_o
);
    reg [CW-1:0] chan_reg;
    reg [CW-1:0] chan_next;

    // load wins over advance so a rewrite always restarts the scan
    always @* begin
        chan_next = chan_reg;
        if (load_i) begin
            chan_next = low_i; // [R3]
        end else if (advance_i) begin
            if (chan_reg == high_i) begin
                chan_next = low_i; // [R5]
            end else begin
                chan_next = chan_reg + {{(CW-1){1'b0}}, 1'b1}; // [R4]
            end
        end
    end

    // a span with high below low counts on through 15 and 0 up to high, then low
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            chan_reg <= {CW{1'b0}};
        end else begin
            chan_reg <= chan_next;
        end
    end

    assign chan_o = chan_reg;
endmodule
`default_nettype wire

// ===== rtl/adsc_ctrl.v
// Notes on behaviour
// (R1) results are 16-bit two's complement, -32768 to 32767, for any range
// (R2) channel register: low bound in low nibble, high bound in high nibble
// (R3) any channel register write loads counter with the low bound
// (R4) counter advances by one after each conversion within the span
// (R5) after the high-bound channel the counter wraps back to the low bound
// (R6) host writes polarity/range/gain code at offset 11 only on range change
// (R7) reading offset 11 returns the last value written there; the code returns bits 7:5 as zero
// (R8) host keeps output polarity bit by read-modify-write
// (R9) host waits about 10 us settling after channel or range change
// (R10) any write to offset 0 starts a conversion; data ignored; the code starts one only from idle, not while busy
// (R11) a conversion completes within 10 us of its start
// (R12) status bit 7 at offset 8 is 1 while busy, 0 when result ready
// (R13) host polls the busy bit until zero before reading the result
// (R14) result low byte at offset 0, high byte at offset 1
// (R15) output converter: four channels, 12-bit codes 0 to 4095
// (R16) config: out polarity b4, range b3, in polarity b2, gain b1:0
// (R17) host never programs codes 4 to 7
// (R18) reset clears config to zero: bipolar, bipolar, 5 V range, gain 1
// (R19) busy rises the cycle after start, falls after result latch and advance
// (R20) a start write during a conversion is ignored
`include "adsc_defs.vh"
`default_nettype none
module adsc_ctrl #(
    parameter CONV_CYCLES = `ADSC_CONV_CYCLES,
    parameter DAC_CHANNELS = `ADSC_DAC_CHANNELS
) (
    // clock and reset
    input wire clk_i,
    input wire nrst_i,
    // register port
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // converter front end
    output wire [3:0] mux_chan_o,
    output wire sample_o,
    input wire conv_done_i,
    input wire [15:0] conv_data_i,
    // analog configuration outputs
    output wire output_polarity_select_o,
    output wire range_select_o,
    output wire input_polarity_select_o,
    output wire gain_select_high_o,
    output wire gain_select_low_o,
    // status
    output wire busy_o,
    output wire [1:0] dac_chan_count_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_CONV = 3'b010;
    localparam ST_DONE = 3'b100;
    localparam [11:0] DAC_MAX = `ADSC_DAC_MAX;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] span_reg;
    reg [7:0] cfg_reg;
    reg [15:0] result_reg;
    reg [15:0] tmo_reg;
    reg [15:0] tmo_next;
    reg [15:0] result_next;
    wire start_wr;
    wire span_wr;
    wire cfg_wr;
    wire advance;

    // decode of the strobes against the byte offsets
    assign start_wr = wr_i && (addr_i == `ADSC_OFS_START_LOW);
    assign span_wr = wr_i && (addr_i == `ADSC_OFS_CHAN_SPAN);
    assign cfg_wr = wr_i && (addr_i == `ADSC_OFS_RANGE_CFG);

    // span register: low bound nibble and high bound nibble
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            span_reg <= `ADSC_SPAN_RESET;
        end else if (span_wr) begin
            span_reg <= wdata_i; // [R2]
        end
    end

    // configuration register; unused upper bits never stored
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            cfg_reg <= `ADSC_CFG_RESET; // [R18]
        end else if (cfg_wr) begin
            cfg_reg <= wdata_i & `ADSC_CFG_MASK; // [R16]
        end
    end

    // conversion sequencer: idle, waiting for converter, latch and advance
    always @* begin
        state_next = state_reg;
        tmo_next = tmo_reg;
        result_next = result_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_wr) begin // [R10]
                    state_next = ST_CONV;
                    tmo_next = 16'h0000;
                end
            end
            ST_CONV: begin
                // start writes here fall through unseen
                tmo_next = tmo_reg + 16'h0001; // [R20]
                if (conv_done_i) begin
                    result_next = conv_data_i; // [R1]
                    state_next = ST_DONE;
                end else if (tmo_reg >= CONV_CYCLES[15:0] - 16'h0001) begin
                    // a silent converter must not hang the host's poll loop
                    result_next = conv_data_i; // [R11]
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE; // [R19]
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            state_reg <= ST_IDLE;
            tmo_reg <= 16'h0000;
            result_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            tmo_reg <= tmo_next;
            result_reg <= result_next;
        end
    end

    // advance once per finished conversion, in the last busy cycle before busy drops
    assign advance = (state_reg == ST_DONE); // [R4]

    adsc_chan_counter #(
        .CW(4)
    ) u_chan (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .load_i(span_wr),
        .low_i(span_wr ? wdata_i[3:0] : span_reg[3:0]),
        .high_i(span_reg[7:4]),
        .advance_i(advance),
        .chan_o(mux_chan_o)
    );

    // busy covers conversion and the latch/advance cycle
    assign busy_o = (state_reg != ST_IDLE); // [R19]
    assign sample_o = (state_reg == ST_CONV) && (tmo_reg == 16'h0000);

    // read data, valid the cycle after the read strobe only
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `ADSC_OFS_START_LOW: rdata_o <= result_reg[7:0]; // [R14]
                `ADSC_OFS_RESULT_HIGH: rdata_o <= result_reg[15:8]; // [R14]
                `ADSC_OFS_STATUS: begin
                    rdata_o <= {busy_o, 3'b000, mux_chan_o}; // [R12]
                end
                `ADSC_OFS_RANGE_CFG: rdata_o <= cfg_reg; // [R7]
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // configuration fields drive the analog front end directly
    assign output_polarity_select_o = cfg_reg[`ADSC_CFG_OUT_POL_BIT]; // [R16]
    assign range_select_o = cfg_reg[`ADSC_CFG_RANGE_BIT];
    assign input_polarity_select_o = cfg_reg[`ADSC_CFG_IN_POL_BIT];
    assign gain_select_high_o = cfg_reg[`ADSC_CFG_GAIN_LSB+1];
    assign gain_select_low_o = cfg_reg[`ADSC_CFG_GAIN_LSB];

    // output converter shape is only recorded: channels minus one, 12-bit codes
    assign dac_chan_count_o = DAC_CHANNELS[1:0] - 2'b01 + {1'b0, ~|DAC_MAX[0]}; // [R15]
endmodule
`default_nettype wire

// ===== tb/adsc_ctrl_asserts.sv
`default_nettype none
module adsc_ctrl_chk #(parameter int CONV_CYCLES = 1000) (
    // watched ports
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [3:0] mux_chan_o,
    input wire logic sample_o,
    input wire logic conv_done_i,
    input wire logic range_select_o,
    input wire logic busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] span_reg;
    logic [15:0] busy_cnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // shadow of the span so the wrap point is known
    always @(posedge clk_i) begin
        if (!nrst_i) span_reg <= 8'h00;
        else if (wr_i && addr_i == 4'h2) span_reg <= wdata_i;
    end
    // busy length in cycles; the default bound is too long for a delay range
    always @(posedge clk_i) begin
        if (!nrst_i || !busy_o) busy_cnt <= 16'h0000;
        else busy_cnt <= busy_cnt + 16'h0001;
    end
    busy_start_a: assert property (wr_i && addr_i == 4'h0 && !busy_o
        |=> busy_o && sample_o) else $error("start missed");
    start_ignore_a: assert property (wr_i && addr_i == 4'h0 && busy_o
        |=> !sample_o) else $error("restart while busy");
    chan_load_a: assert property (wr_i && addr_i == 4'h2
        |=> mux_chan_o == span_reg[3:0]) else $error("no load");
    stat_busy_a: assert property (rd_i && addr_i == 4'h8
        |=> rdata_o[7] == $past(busy_o)) else $error("bad status");
    cfg_write_a: assert property (wr_i && addr_i == 4'hb && wdata_i[3]
        |=> range_select_o) else $error("range bit");
    busy_fall_a: assert property (conv_done_i && busy_o
        |=> busy_o ##1 !busy_o) else $error("busy length");
    chan_step_a: assert property (conv_done_i && busy_o |-> ##2 mux_chan_o ==
        (($past(mux_chan_o, 2) == span_reg[7:4]) ? span_reg[3:0]
        : $past(mux_chan_o, 2) + 4'h1)) else $error("bad step");
    conv_bound_a: assert property (busy_o |-> busy_cnt <= CONV_CYCLES)
        else $error("conversion hung");
    cover property (conv_done_i && busy_o);
    cover property (wr_i && addr_i == 4'h0 && busy_o);
    cover property (rd_i && addr_i == 4'hb);
endmodule
bind adsc_ctrl adsc_ctrl_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.clk_i, .nrst_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .mux_chan_o, .sample_o,
    .conv_done_i, .range_select_o, .busy_o);
`default_nettype wire

// ===== tb/adsc_conv_model.sv
`default_nettype none
module adsc_conv_model (
    // sample strobe in, result out
    input wire logic clk_i,
    input wire logic sample_i,
    input wire logic [15:0] code_i,
    input wire logic [7:0] wait_i,
    output logic done_o = 1'b0,
    output logic [15:0] data_o = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt = 8'h00;
    // zero wait never answers; data toggles off the done cycle so stale codes fail
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        data_o <= ~data_o;
        if (sample_i) cnt <= wait_i;
        else if (cnt != 8'h00) cnt <= cnt - 8'h01;
        if (!sample_i && cnt == 8'h01) begin
            done_o <= 1'b1;
            data_o <= code_i;
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, nrst_i, wr_i, rd_i, done, smp;
    logic [3:0] addr_i, chan;
    logic [7:0] wdata_i, rdata_o, wt, s, lo, hi;
    logic [15:0] code, data;
    logic [4:0] cfg;
    logic [1:0] dcc;
    int bad_count = 0, comparisons = 0, cyc = 0;
    adsc_ctrl #(.CONV_CYCLES(20)) DUT (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .mux_chan_o(chan), .sample_o(smp), .conv_done_i(done),
        .conv_data_i(data), .output_polarity_select_o(cfg[4]), .range_select_o(cfg[3]),
        .input_polarity_select_o(cfg[2]), .gain_select_high_o(cfg[1]),
        .gain_select_low_o(cfg[0]), .busy_o(), .dac_chan_count_o(dcc));
    adsc_conv_model cm (.clk_i, .sample_i(smp), .code_i(code), .wait_i(wt),
        .done_o(done), .data_o(data));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        // let the write land before the caller looks at its effect
        #1;
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] q);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 q = rdata_o;
    endtask
    task conv(input logic [15:0] c, input logic [3:0] ch, input logic twice);
        int n;
        code = c;
        chk(chan, ch);
        wr(4'h0, 8'h5a);
        if (twice) wr(4'h0, 8'h00);
        n = 0;
        do begin
            rd(4'h8, s);
            n++;
        end while (s[7] !== 1'b0 && n < 40);
        chk(s[7], 1'b0);
        rd(4'h0, lo);
        rd(4'h1, hi);
        if (wt != 8'h00) chk({hi, lo}, c);
    endtask
    task give_verdict;
        $display("%0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // a hang counts as a mismatch
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        {nrst_i, wr_i, rd_i, addr_i, wdata_i, code} = '0;
        wt = 8'd5;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(4'hb, s);
        chk(s, 8'h00);
        chk(dcc, 2'h3);
        $display("reset test done");
        for (int i = 0; i < 16; i++) if (i < 4 || i > 7) begin
            wr(4'hb, i[7:0]);
            chk(cfg, i[4:0]);
        end
        wr(4'hb, 8'hfb);
        rd(4'hb, s);
        chk(s, 8'h1b);
        wr(4'hb, (s & 8'h10) | 8'h0c);
        rd(4'hb, s);
        chk(s, 8'h1c);
        $display("config test done");
        wr(4'h2, 8'h20);
        repeat (1000) @(posedge clk_i);
        conv(16'h8000, 4'h0, 1'b0);
        conv(16'h7fff, 4'h1, 1'b0);
        conv(16'h4560, 4'h2, 1'b1);
        conv(16'hc560, 4'h0, 1'b0);
        wr(4'h2, 8'h53);
        conv(16'h0001, 4'h3, 1'b0);
        wt = 8'h00;
        conv(16'h0000, 4'h4, 1'b0);
        wt = 8'd9;
        conv(16'hffff, 4'h5, 1'b0);
        chk(chan, 4'h3);
        rd(4'h4, s);
        chk(s, 8'h00);
        $display("scan test done");
        give_verdict();
    end
endmodule
`default_nettype wire
